// file: rtl/port_arb_regs.svh
// register offsets, field layout, reset values and sizes of the port arbitration phase tables
// assumes a 12-bit byte address on the register bus, one 32-bit word per register
`ifndef PORT_ARB_REGS_SVH
`define PORT_ARB_REGS_SVH

// ==========================================================
// offsets (byte addresses)
`define VC0_ARB_TABLE_WORD0_OFF 12'h0230
`define VC0_ARB_TABLE_WORD3_OFF 12'h023C
`define VC1_ARB_TABLE_WORD0_OFF 12'h0240
`define VC1_ARB_TABLE_WORD1_OFF 12'h0244
`define VC1_ARB_TABLE_WORD3_OFF 12'h024C

// ==========================================================
// field layout
`define SLOT_FIELD_WIDTH        4
`define SLOTS_PER_WORD          8
`define TABLE_WORDS             4
`define TABLE_SLOTS             32

// ==========================================================
// reset values, lowest phase in bits 3:0
`define VC0_ARB_TABLE_WORD0_RST 32'h3322_1100
`define VC0_ARB_TABLE_WORD1_RST 32'h7766_5544
`define VC0_ARB_TABLE_WORD2_RST 32'hBBAA_9988
`define VC0_ARB_TABLE_WORD3_RST 32'hFFEE_DDCC
`define VC1_ARB_TABLE_WORD0_RST 32'h4433_2100
`define VC1_ARB_TABLE_WORD1_RST 32'h7766_5544
`define VC1_ARB_TABLE_WORD2_RST 32'hBBAA_9988
`define VC1_ARB_TABLE_WORD3_RST 32'hFFEE_DDCC

`endif

// file: rtl/port_arb_pkg.sv
// types shared by the port arbitration phase table
// assumes port_arb_regs.svh is on the include path
package port_arb_pkg;
  `include "port_arb_regs.svh"

  typedef logic [3:0] port_id_type;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  // complete state of the block
  typedef struct packed {
    logic [1:0][3:0][31:0] tbl;
    logic [1:0][4:0]       ptr;
    logic [1:0]            gValid;
    logic [1:0][3:0]       gPort;
    logic [1:0][4:0]       gSlot;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  started;
  } state_type;
endpackage : port_arb_pkg

// file: rtl/port_arbitration_phase_table.sv
// two programmable 32-slot port arbitration phase tables, one per vc resource,
// each driving a grant for the egress port
// assumes a classic wishbone master on the same clock and ingress queues that
// pulse periodDone when an arbitration period ends
// ==========================================================
// Summary of operation
// - each 4-bit slot holds a port id that is granted during its period
// - codes 0 to 15 select ports 0 to 15, port 0 is upstream
// - eight slots per table word, lowest phase at bits 3:0 upward
// - vc1 slots 0 to 7 reset to 0,0,1,2,3,3,4,4
// - vc0 slots 24 to 31 reset to C,C,D,D,E,E,F,F
// - vc1 slots 8,9 reset to 4, slot 10 to 5; all slots read/write
`timescale 1ns/10ps

module port_arbitration_phase_table
  import port_arb_pkg::*;
#(
  parameter port_id_type  EGRESS_ID    = 4'h0,
  parameter logic [15:0]  PORT_PRESENT = 16'hFFFF
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire wb_req_type       wbReq,
  output logic [31:0]           wbDatO,
  output logic                  wbAck,
  input  wire logic [1:0]       periodDone,
  input  wire logic [1:0][15:0] ingressReq,
  output logic [1:0]            grantValid,
  output logic [1:0][3:0]       grantPort,
  output logic [1:0][15:0]      grantOh
);

  // ==========================================================
  // reset image
  localparam state_type RST_STATE = '{
    tbl: '{'{`VC1_ARB_TABLE_WORD3_RST, `VC1_ARB_TABLE_WORD2_RST,
             `VC1_ARB_TABLE_WORD1_RST, `VC1_ARB_TABLE_WORD0_RST},
           '{`VC0_ARB_TABLE_WORD3_RST, `VC0_ARB_TABLE_WORD2_RST,
             `VC0_ARB_TABLE_WORD1_RST, `VC0_ARB_TABLE_WORD0_RST}},
    default: '0
  };

  state_type st_ff;
  state_type nxt_st;

  // reserved ports and our own egress never win a slot
  function automatic logic portOk(input port_id_type id);
    portOk = PORT_PRESENT[id] && (id != EGRESS_ID);
  endfunction : portOk

  function automatic port_id_type slotId(input logic [3:0][31:0] t, input logic [4:0] idx);
    slotId = t[idx[4:3]][{idx[2:0], 2'b00} +: `SLOT_FIELD_WIDTH];
  endfunction : slotId

  // ==========================================================
  // register bus decode
  logic        busHit;
  logic        busVc;
  logic [1:0]  busWord;
  logic [11:0] busOff;

  // both tables are one contiguous window: bit 4 of the offset picks the vc,
  // bits 3:2 the word; anything outside the window is acked and reads zero
  assign busOff  = wbReq.adr - `VC0_ARB_TABLE_WORD0_OFF;
  assign busHit  = (wbReq.adr >= `VC0_ARB_TABLE_WORD0_OFF) && (wbReq.adr <= `VC1_ARB_TABLE_WORD3_OFF);
  assign busVc   = busOff[4];
  assign busWord = busOff[3:2];

  // ==========================================================
  // next state
  logic       found;
  logic [4:0] idx;
  logic [4:0] eff;

  always_comb begin
    nxt_st  = st_ff;
    found   = 1'b0;
    idx     = '0;
    eff     = '0;
    nxt_st.ack     = 1'b0;
    nxt_st.started = 1'b1;
    // one wait state; unmapped addresses still ack and read zero
    if (wbReq.cyc && wbReq.stb && !st_ff.ack) begin
      nxt_st.ack  = 1'b1;
      nxt_st.rdat = '0;
      if (busHit && !wbReq.we) begin
        nxt_st.rdat = st_ff.tbl[busVc][busWord];
      end
      for (int b = 0; b < 4; b++) begin
        if (busHit && wbReq.we && wbReq.sel[b]) begin
          nxt_st.tbl[busVc][busWord][8*b +: 8] = wbReq.dat[8*b +: 8];
        end
      end
    end
    // the search reads the table as it stood before this cycle's write, so a
    // rewritten slot shows up in the grant one cycle after the write is acked
    for (int v = 0; v < 2; v++) begin
      found = 1'b0;
      eff   = st_ff.ptr[v];
      // search forward so invalid slots cost no period
      for (int o = 0; o < `TABLE_SLOTS; o++) begin
        idx = st_ff.ptr[v] + o[4:0];
        if (!found && portOk(slotId(st_ff.tbl[v], idx))) begin
          found = 1'b1;
          eff   = idx;
        end
      end
      nxt_st.gValid[v] = found;
      nxt_st.gSlot[v]  = eff;
      nxt_st.gPort[v]  = slotId(st_ff.tbl[v], eff);
      // advance from the slot the queues actually saw; 5 bits wrap 31 to 0
      if (periodDone[v] && st_ff.gValid[v]) begin
        nxt_st.ptr[v] = st_ff.gSlot[v] + 5'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= RST_STATE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign wbAck      = st_ff.ack;
  assign wbDatO     = st_ff.rdat;
  assign grantValid = st_ff.gValid;
  assign grantPort  = st_ff.gPort;

  for (genvar v = 0; v < 2; v++) begin : g_oh
    assign grantOh[v] = st_ff.gValid[v] ? ((16'h0001 << st_ff.gPort[v]) & ingressReq[v]) : 16'h0000;
  end

  // ==========================================================
  // assertions
  grant_onehot_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[0] && ingressReq[0][grantPort[0]] |-> grantOh[0] == (16'h0001 << grantPort[0]))
    else $error("grant one-hot does not name the slot port");
  skip_invalid_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[1] |-> PORT_PRESENT[grantPort[1]] && grantPort[1] != EGRESS_ID)
    else $error("invalid port granted");
  port_encode_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[0] && $past(ce) |-> grantPort[0] == slotId($past(st_ff.tbl[0]), st_ff.gSlot[0]))
    else $error("granted port differs from slot code");
  port_encode_vc1_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[1] && $past(ce) |-> grantPort[1] == slotId($past(st_ff.tbl[1]), st_ff.gSlot[1]))
    else $error("vc1 granted port differs from slot code");
  packing_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && wbReq.cyc && wbReq.stb && !wbAck && !wbReq.we && wbReq.adr == `VC1_ARB_TABLE_WORD0_OFF
      |=> wbAck && wbDatO[3:0] == slotId($past(st_ff.tbl[1]), 5'd0) && wbDatO[31:28] == slotId($past(st_ff.tbl[1]), 5'd7))
    else $error("slot packing wrong on read");
  vc1_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    !st_ff.started |-> st_ff.tbl[1][0] == 32'h4433_2100)
    else $error("vc1 slots 0-7 reset wrong");
  vc0_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    !st_ff.started |-> st_ff.tbl[0][3] == 32'hFFEE_DDCC)
    else $error("vc0 slots 24-31 reset wrong");
  table_write_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && wbReq.cyc && wbReq.stb && !wbAck && wbReq.we && wbReq.sel == 4'hF
      && wbReq.adr == `VC1_ARB_TABLE_WORD1_OFF |=> st_ff.tbl[1][1] == $past(wbReq.dat))
    else $error("table write not stored");
  vc1_slot8_a: assert property (@(posedge clk) disable iff (!rstn)
    !st_ff.started |-> st_ff.tbl[1][1][11:0] == 12'h544)
    else $error("vc1 slots 8-10 reset wrong");
  step_order_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && periodDone[0] && grantValid[0] |=> st_ff.ptr[0] == $past(st_ff.gSlot[0]) + 5'd1)
    else $error("pointer did not step to next slot");

  // ==========================================================
  // per-vc twins of the checks above, plus a vc1 idle one-hot check and a vc0 pointer hold; vc1 runs on its reset table with word 1 rewritten, vc0 on
  // whatever software loads, so between them both paths see real traffic
  grant_onehot_vc1_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[1] && ingressReq[1][grantPort[1]] |-> grantOh[1] == (16'h0001 << grantPort[1]))
    else $error("vc1 grant one-hot does not name the slot port");
  grant_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !grantValid[1] |-> grantOh[1] == 16'h0000)
    else $error("one-hot grant raised without a valid slot");
  skip_invalid_vc0_a: assert property (@(posedge clk) disable iff (!rstn)
    grantValid[0] |-> PORT_PRESENT[grantPort[0]] && grantPort[0] != EGRESS_ID)
    else $error("vc0 invalid port granted");
  step_order_vc1_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && periodDone[1] && grantValid[1] |=> st_ff.ptr[1] == $past(st_ff.gSlot[1]) + 5'd1)
    else $error("vc1 pointer did not step to next slot");
  ptr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !(periodDone[0] && grantValid[0]) |=> st_ff.ptr[0] == $past(st_ff.ptr[0]))
    else $error("pointer moved without a period end");

  // ==========================================================
  // bus and clock-enable behaviour
  // a held ack would let a slow master be served twice
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    wbAck |=> !wbAck)
    else $error("ack stood longer than one cycle");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && wbReq.cyc && wbReq.stb && !wbAck && !wbReq.we
      && (wbReq.adr < `VC0_ARB_TABLE_WORD0_OFF || wbReq.adr > `VC1_ARB_TABLE_WORD3_OFF)
      |=> wbAck && wbDatO == 32'h0000_0000)
    else $error("unmapped read did not return zero");
  rdat_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !(wbReq.cyc && wbReq.stb && !wbAck) |=> $stable(wbDatO))
    else $error("read data changed without a request");
  // a frozen block must not advance even if the queues keep pulsing
  freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(st_ff))
    else $error("state changed while clock enable was low");

  grant_vc0_c: cover property (@(posedge clk) disable iff (!rstn) |grantOh[0]);
  grant_vc1_c: cover property (@(posedge clk) disable iff (!rstn) |grantOh[1]);
  freeze_seen_c: cover property (@(posedge clk) disable iff (!rstn) !ce && wbReq.cyc && wbReq.stb);
  skip_seen_c: cover property (@(posedge clk) disable iff (!rstn) grantValid[1] && st_ff.gSlot[1] != st_ff.ptr[1]);
  wrap_seen_c: cover property (@(posedge clk) disable iff (!rstn) ce && periodDone[0] && st_ff.gSlot[0] == 5'd31);

endmodule : port_arbitration_phase_table

// file: dv/ingress_queue_model.sv
// ingress queue model: random request levels and paced period-end pulses
// assumes the arbiter samples periodDone on the rising edge of clk
`timescale 1ns/10ps
module ingress_queue_model (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             go,
  input  wire logic [1:0]       grantValid,
  output logic [1:0]            periodDone,
  output logic [1:0][15:0]      ingressReq
);
  // ==========================================================
  // pacing
  logic [1:0] cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      periodDone <= '0;
      ingressReq <= '0;
    end else begin
      cnt_ff <= (cnt_ff == 2'd2) ? 2'd0 : cnt_ff + 2'd1;
      ingressReq <= 32'($urandom);
      // one pulse in three cycles, an advance from a stale slot is never provoked
      periodDone <= (go && cnt_ff == 2'd0) ? grantValid : 2'b00;
    end
  end
endmodule : ingress_queue_model

// file: dv/port_arbitration_phase_table_test.sv
// self-checking bench for the phase table arbiter
// assumes a wishbone ack one cycle after the request is taken
`timescale 1ns/10ps
module port_arbitration_phase_table_test;
  import port_arb_pkg::*;
  // ==========================================================
  // setup
  localparam port_id_type EGR  = 4'hF;
  localparam logic [15:0] PRES = 16'hFFDF;
  logic             clk, rstn, go, wbAck, ce;
  wb_req_type       wbReq;
  logic [31:0]      wbDatO;
  logic [1:0]       periodDone, grantValid, d1, d2;
  logic [1:0][15:0] ingressReq, grantOh;
  logic [1:0][3:0]  grantPort;
  logic [31:0]      rq[$], mq[$];
  port_id_type      gq[$], tb[32];
  int               n_errors, num_checks;

  port_arbitration_phase_table #(.EGRESS_ID(EGR), .PORT_PRESENT(PRES)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
    .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .periodDone(periodDone), .ingressReq(ingressReq),
    .grantValid(grantValid), .grantPort(grantPort), .grantOh(grantOh));
  ingress_queue_model partner (.clk(clk), .rstn(rstn), .go(go), .grantValid(grantValid),
    .periodDone(periodDone), .ingressReq(ingressReq));

  function automatic bit ok(port_id_type p);
    return PRES[p] && p != EGR;
  endfunction : ok

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chkWord

  task automatic chkGrant(input logic [3:0] got, input logic [15:0] oh, input logic [3:0] exp);
    chkWord({28'h0, got}, {28'h0, exp}, "grant port");
    chkWord({16'h0, oh}, {16'h0, ingressReq[0] & (16'h1 << exp)}, "grant onehot");
  endtask : chkGrant

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, m, e);
    int t;
    if (!w) begin
      rq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wbAck !== 1'b1 && t < 50);
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    if (t == 50) n_errors++;
  endtask : wb

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // watcher, clock and watchdog
  always @(posedge clk) begin
    d1 <= periodDone & grantValid;
    d2 <= d1;
    if (wbAck === 1'b1 && !wbReq.we && rq.size() > 0) chkWord(wbDatO & mq.pop_front(), rq.pop_front(), "read");
    if (d2[0] === 1'b1 && gq.size() > 0) chkGrant(grantPort[0], grantOh[0], gq.pop_front());
  end

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end

  // ==========================================================
  // tests
  initial begin
    int cur;
    logic [31:0] w;
    rstn = 0;
    go = 0;
    ce = 1;
    wbReq = '0;
    d1 = 0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(75006));
    repeat (20) @(posedge clk);
    rstn <= 1;
    wb(0, 12'h23C, 0, 32'hFFFF_FFFF, 32'hFFEE_DDCC);
    wb(0, 12'h240, 0, 32'hFFFF_FFFF, 32'h4433_2100);
    wb(0, 12'h244, 0, 32'h0000_0FFF, 32'h0000_0544);
    $display("reset value test done");
    w = $urandom;
    wb(1, 12'h244, w, 0, 0);
    wb(0, 12'h244, 0, 32'hFFFF_FFFF, w);
    wb(1, 12'h250, w, 0, 0);
    wb(0, 12'h250, 0, 32'hFFFF_FFFF, 0);
    // a request made while frozen is answered only once clock enable returns
    ce <= 0;
    fork
      wb(0, 12'h23C, 0, 32'hFFFF_FFFF, 32'hFFEE_DDCC);
      begin
        repeat (6) @(posedge clk);
        ce <= 1;
      end
    join
    $display("access test done");
    for (int n = 0; n < 32; n++) begin
      do tb[n] = 4'($urandom); while (tb[n] == EGR);
      w[4*(n%8)+:4] = tb[n];
      if (n % 8 == 7) wb(1, 12'h230 + 12'(4 * (n / 8)), w, 0, 0);
    end
    // the first hit is the standing grant, later hits follow each advance
    cur = 31;
    for (int k = 0; k < 41; k++) begin
      for (int s = 0; s < 32; s++) begin
        cur = (cur + 1) % 32;
        if (ok(tb[cur])) break;
      end
      if (k > 0) gq.push_back(tb[cur]);
    end
    repeat (3) @(posedge clk);
    go <= 1;
    for (int t = 0; t < 400 && gq.size() > 0; t++) @(posedge clk);
    go <= 0;
    if (gq.size() > 0) n_errors++;
    $display("arbitration test done");
    end_of_test();
  end
endmodule : port_arbitration_phase_table_test
